// [design/ipo_pkg.sv]
// Constants and types for the indirect pointer operand block
package ipo_pkg;

    localparam int NUM_PAIRS = 3;
    localparam int PTR_W = 16;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PAIR_IDX_W = 2;

    // Data-space base of each pair's group of eight addresses
    localparam logic [ADDR_W-1:0] PAIR_BASE [0:NUM_PAIRS-1] = '{12'hFE8, 12'hFE0, 12'hFD8};
    localparam logic [ADDR_W-1:0] GROUP_MASK = 12'hFF8;

    // Slot of each address inside a group
    localparam logic [2:0] SLOT_PLAIN = 3'h0;
    localparam logic [2:0] SLOT_POST_DECREMENT_OPERAND = 3'h1;
    localparam logic [2:0] SLOT_POST_INCREMENT_OPERAND = 3'h2;
    localparam logic [2:0] SLOT_PRE_INCREMENT_OPERAND = 3'h3;
    localparam logic [2:0] SLOT_INDEXED = 3'h4;
    localparam logic [2:0] SLOT_LOW = 3'h5;
    localparam logic [2:0] SLOT_HIGH = 3'h6;

    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [PTR_W-1:0] PTR_STEP = 16'h0001;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;

    typedef enum logic [2:0] {
        IPO_OP_PLAIN,
        IPO_OP_POST_DECREMENT_OPERAND,
        IPO_OP_POST_INCREMENT_OPERAND,
        IPO_OP_PRE_INCREMENT_OPERAND,
        IPO_OP_INDEXED
    } ipo_op_t;

endpackage : ipo_pkg

// [design/ipo_pointer_ops.sv]
// Indirect pointer operand logic: effective address and pointer pair update
// What this block does
// - Each pointer pair has four extra operands besides plain, each with its own action.
// - Post-decrement uses current pointer as address, then subtracts one.
// - Post-increment uses current pointer as address, then adds one.
// - Pre-increment adds one first, then uses the new value as address.
// - Indexed uses pointer plus signed working register; neither is changed.
// - Plain operand uses pointer directly and leaves it unchanged.
// - Steps act on the whole 16-bit pair, carrying between low and high byte.
// - Pointer arithmetic never touches any status flag.
// - Operand addresses hold no storage and are not valid indirect targets.
// - Indirect read of an operand address gives 00h; a write does nothing.
// - Write through an operand onto a pointer byte stores it; that pair is not stepped, but the accessed pair still is.
`timescale 1ns/1ps
module ipo_pointer_ops (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic acc_valid,
    input wire logic [ipo_pkg::PAIR_IDX_W-1:0] acc_pair,
    input wire ipo_pkg::ipo_op_t acc_op,
    input wire logic acc_write,
    input wire logic [ipo_pkg::DATA_W-1:0] acc_wdata,
    input wire logic [ipo_pkg::DATA_W-1:0] work_reg,
    input wire logic dir_we,
    input wire logic [ipo_pkg::ADDR_W-1:0] dir_addr,
    input wire logic [ipo_pkg::DATA_W-1:0] dir_wdata,
    output logic mem_valid,
    output logic mem_we,
    output logic [ipo_pkg::ADDR_W-1:0] mem_addr,
    output logic [ipo_pkg::DATA_W-1:0] mem_wdata,
    output logic rd_zero,
    output logic [ipo_pkg::NUM_PAIRS-1:0][ipo_pkg::PTR_W-1:0] ptr_pairs
);

    // True when the address is one of the five operand slots of any pair
    function automatic logic oper_hit(input logic [ipo_pkg::ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < ipo_pkg::NUM_PAIRS; i++) begin
            if ((a & ipo_pkg::GROUP_MASK) == ipo_pkg::PAIR_BASE[i]
                && a[2:0] <= ipo_pkg::SLOT_INDEXED) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : oper_hit

    // Decodes a pointer byte address into {hit, high, pair}
    function automatic logic [3:0] byte_hit(input logic [ipo_pkg::ADDR_W-1:0] a);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < ipo_pkg::NUM_PAIRS; i++) begin
            if ((a & ipo_pkg::GROUP_MASK) == ipo_pkg::PAIR_BASE[i]) begin
                if (a[2:0] == ipo_pkg::SLOT_LOW) begin
                    r = {1'b1, 1'b0, i[1:0]};
                end else if (a[2:0] == ipo_pkg::SLOT_HIGH) begin
                    r = {1'b1, 1'b1, i[1:0]};
                end
            end
        end
        return r;
    endfunction : byte_hit

    logic [ipo_pkg::NUM_PAIRS-1:0][ipo_pkg::PTR_W-1:0] ptr_q, ptr_d;
    logic mem_valid_q, mem_valid_d;
    logic mem_we_q, mem_we_d;
    logic [ipo_pkg::ADDR_W-1:0] mem_addr_q, mem_addr_d;
    logic [ipo_pkg::DATA_W-1:0] mem_wdata_q, mem_wdata_d;
    logic rd_zero_q, rd_zero_d;

    logic acc_ok;
    logic [ipo_pkg::PTR_W-1:0] cur, ea, nxt;
    logic [ipo_pkg::ADDR_W-1:0] ea_addr;
    logic ea_virt;
    logic [3:0] ea_byte, dir_byte;
    logic self_wr;

    always_comb begin
        // Pair index past the last pair is not an access
        acc_ok = acc_valid && (acc_pair < 2'(ipo_pkg::NUM_PAIRS));
        cur = ptr_q[acc_pair];
        ea = cur;
        nxt = cur;
        // Full-width arithmetic, no flag output exists at all
        case (acc_op)
            ipo_pkg::IPO_OP_PLAIN: begin
                ea = cur;
                nxt = cur;
            end
            ipo_pkg::IPO_OP_POST_DECREMENT_OPERAND: begin
                ea = cur;
                nxt = cur - ipo_pkg::PTR_STEP;
            end
            ipo_pkg::IPO_OP_POST_INCREMENT_OPERAND: begin
                ea = cur;
                nxt = cur + ipo_pkg::PTR_STEP;
            end
            ipo_pkg::IPO_OP_PRE_INCREMENT_OPERAND: begin
                ea = cur + ipo_pkg::PTR_STEP;
                nxt = ea;
            end
            ipo_pkg::IPO_OP_INDEXED: begin
                ea = cur + {{8{work_reg[7]}}, work_reg};
                nxt = cur;
            end
            default: begin
                ea = cur;
                nxt = cur;
            end
        endcase
        ea_addr = ea[ipo_pkg::ADDR_W-1:0];
        ea_virt = oper_hit(ea_addr);
        ea_byte = byte_hit(ea_addr);
        dir_byte = byte_hit(dir_addr);
        self_wr = acc_ok && acc_write && ea_byte[3];
    end

    // Pointer pairs
    always_comb begin
        ptr_d = ptr_q;
        if (acc_ok) begin
            ptr_d[acc_pair] = nxt;
            if (self_wr) begin
                // Written pair keeps its value apart from the stored byte
                ptr_d[ea_byte[1:0]] = ptr_q[ea_byte[1:0]];
                if (ea_byte[2]) begin
                    ptr_d[ea_byte[1:0]][15:8] = acc_wdata;
                end else begin
                    ptr_d[ea_byte[1:0]][7:0] = acc_wdata;
                end
            end
        end else if (dir_we && dir_byte[3]) begin
            // Direct write is only honoured outside an operand access
            if (dir_byte[2]) begin
                ptr_d[dir_byte[1:0]][15:8] = dir_wdata;
            end else begin
                ptr_d[dir_byte[1:0]][7:0] = dir_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= '{default: ipo_pkg::PTR_RST};
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // Memory request
    always_comb begin
        mem_addr_d = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        mem_valid_d = 1'b0;
        mem_we_d = 1'b0;
        rd_zero_d = 1'b0;
        if (acc_ok) begin
            mem_addr_d = ea_addr;
            mem_wdata_d = acc_wdata;
            // Operand slots have no storage: no memory cycle at all
            mem_valid_d = !ea_virt && !self_wr;
            mem_we_d = acc_write && !ea_virt && !self_wr;
            rd_zero_d = ea_virt && !acc_write;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mem_valid_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= ipo_pkg::ADDR_RST;
            mem_wdata_q <= ipo_pkg::ZERO_BYTE;
            rd_zero_q <= 1'b0;
        end else begin
            mem_valid_q <= mem_valid_d;
            mem_we_q <= mem_we_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
            rd_zero_q <= rd_zero_d;
        end
    end

    assign mem_valid = mem_valid_q;
    assign mem_we = mem_we_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    assign rd_zero = rd_zero_q;
    assign ptr_pairs = ptr_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic plain_go, dec_go, inc_go, pre_go, idx_go;
    assign plain_go = acc_ok && acc_op == ipo_pkg::IPO_OP_PLAIN && !self_wr;
    assign dec_go = acc_ok && acc_op == ipo_pkg::IPO_OP_POST_DECREMENT_OPERAND && !self_wr;
    assign inc_go = acc_ok && acc_op == ipo_pkg::IPO_OP_POST_INCREMENT_OPERAND && !self_wr;
    assign pre_go = acc_ok && acc_op == ipo_pkg::IPO_OP_PRE_INCREMENT_OPERAND && !self_wr;
    assign idx_go = acc_ok && acc_op == ipo_pkg::IPO_OP_INDEXED && !self_wr;

    post_decrement_operand_step_a: assert property (dec_go |=> ptr_q[$past(acc_pair)]
        == $past(cur) - 16'h0001 && mem_addr == $past(cur[11:0]))
        else $error("post-decrement pointer or address wrong");
    post_increment_operand_step_a: assert property (inc_go |=> ptr_q[$past(acc_pair)]
        == $past(cur) + 16'h0001 && mem_addr == $past(cur[11:0]))
        else $error("post-increment pointer or address wrong");
    pre_increment_operand_step_a: assert property (pre_go |=> ptr_q[$past(acc_pair)]
        == $past(cur) + 16'h0001 && mem_addr == ptr_q[$past(acc_pair)][11:0])
        else $error("pre-increment pointer or address wrong");
    indexed_addr_a: assert property (idx_go |=> ptr_q[$past(acc_pair)]
        == $past(cur) && mem_addr == 12'($past(cur) + {{8{$past(work_reg[7])}}, $past(work_reg)}))
        else $error("indexed address wrong or pointer changed");
    plain_keep_a: assert property (plain_go |=> ptr_q[$past(acc_pair)]
        == $past(cur) && mem_addr == $past(cur[11:0]))
        else $error("plain operand changed pointer or address");
    carry_high_a: assert property (inc_go && cur[7:0] == 8'hFF
        |=> ptr_q[$past(acc_pair)][15:8] == $past(cur[15:8]) + 8'h01)
        else $error("low byte wrap did not carry");
    virt_read_zero_a: assert property (acc_ok && ea_virt && !acc_write
        |=> rd_zero && !mem_valid && !mem_we)
        else $error("virtual read did not give zero");
    virt_write_nop_a: assert property (acc_ok && ea_virt && acc_write
        |=> !mem_valid && !mem_we && !rd_zero && ptr_q == $past(ptr_d))
        else $error("virtual write reached memory");
    self_write_a: assert property (self_wr && !ea_byte[2]
        |=> ptr_q[$past(ea_byte[1:0])] == {$past(ptr_q[ea_byte[1:0]][15:8]), $past(acc_wdata)})
        else $error("pointer write was stepped");
    next_sees_a: assert property (acc_ok && !acc_write |=> ptr_q == $past(ptr_d))
        else $error("pointer update late");

    cover_dec_c: cover property (dec_go ##1 dec_go);
    cover_idx_c: cover property (idx_go && work_reg[7]);
    cover_virt_c: cover property (acc_ok && ea_virt);
    cover_self_c: cover property (self_wr);

endmodule : ipo_pointer_ops

// [dv/ipo_core_model.sv]
// Core-side data memory model facing the pointer operand block
`timescale 1ns/1ps
module ipo_core_model (
    input wire logic sys_clk,
    input wire logic mem_valid,
    input wire logic mem_we,
    input wire logic [ipo_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [ipo_pkg::DATA_W-1:0] mem_wdata,
    input wire logic rd_zero,
    output logic [ipo_pkg::DATA_W-1:0] rdata_q
);
    logic [ipo_pkg::DATA_W-1:0] mem [0:2**ipo_pkg::ADDR_W-1];
    always @(posedge sys_clk) begin
        if (mem_valid && mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end else if (mem_valid) begin
            rdata_q <= mem[mem_addr];
        end else if (rd_zero) begin
            // Operand slot read: core substitutes zero
            rdata_q <= ipo_pkg::ZERO_BYTE;
        end
    end
endmodule : ipo_core_model

// [dv/ipo_pointer_ops_tb.sv]
// Self-checking bench for the indirect pointer operand block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module ipo_pointer_ops_tb;
    logic sys_clk, rstn, acc_valid, acc_write, dir_we, mem_valid, mem_we, rd_zero;
    logic [1:0] acc_pair;
    ipo_pkg::ipo_op_t acc_op;
    logic [7:0] acc_wdata, work_reg, dir_wdata, mem_wdata, rdata_q;
    logic [11:0] dir_addr, mem_addr;
    logic [2:0][15:0] ptr_pairs;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    ipo_pointer_ops i_dut (.sys_clk(sys_clk), .rstn(rstn), .acc_valid(acc_valid),
        .acc_pair(acc_pair), .acc_op(acc_op), .acc_write(acc_write), .acc_wdata(acc_wdata),
        .work_reg(work_reg), .dir_we(dir_we), .dir_addr(dir_addr), .dir_wdata(dir_wdata),
        .mem_valid(mem_valid), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .rd_zero(rd_zero), .ptr_pairs(ptr_pairs));
    ipo_core_model i_core (.sys_clk(sys_clk), .mem_valid(mem_valid), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .rd_zero(rd_zero), .rdata_q(rdata_q));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic give_verdict;
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // Whole run needs under a hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic dwrite(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        dir_we <= 1'b1;
        dir_addr <= a;
        dir_wdata <= d;
        @(posedge sys_clk);
        dir_we <= 1'b0;
    endtask : dwrite
    task automatic set_ptr(input int p, input logic [15:0] v);
        dwrite(ipo_pkg::PAIR_BASE[p] + 12'h005, v[7:0]);
        dwrite(ipo_pkg::PAIR_BASE[p] + 12'h006, v[15:8]);
    endtask : set_ptr
    task automatic access(input logic [1:0] p, input ipo_pkg::ipo_op_t op, input logic wr,
        input logic [7:0] wd, input logic [7:0] w);
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_pair <= p;
        acc_op <= op;
        acc_write <= wr;
        acc_wdata <= wd;
        work_reg <= w;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        #1;
    endtask : access
    task automatic chk(input logic v, input logic [11:0] a, input int p, input logic [15:0] e);
        `CHK(mem_valid, v)
        if (v) `CHK(mem_addr, a)
        `CHK(ptr_pairs[p], e)
    endtask : chk
    task automatic t_steps;
        set_ptr(0, 16'h00FF);
        access(2'h0, ipo_pkg::IPO_OP_POST_INCREMENT_OPERAND, 1'b0, 8'h00, 8'h00);
        chk(1'b1, 12'h0FF, 0, 16'h0100);
        access(2'h0, ipo_pkg::IPO_OP_POST_DECREMENT_OPERAND, 1'b0, 8'h00, 8'h00);
        chk(1'b1, 12'h100, 0, 16'h00FF);
        access(2'h0, ipo_pkg::IPO_OP_PRE_INCREMENT_OPERAND, 1'b0, 8'h00, 8'h00);
        chk(1'b1, 12'h100, 0, 16'h0100);
        set_ptr(1, 16'h0000);
        access(2'h1, ipo_pkg::IPO_OP_POST_DECREMENT_OPERAND, 1'b0, 8'h00, 8'h00);
        chk(1'b1, 12'h000, 1, 16'hFFFF);
    endtask : t_steps
    task automatic t_index;
        set_ptr(2, 16'h0100);
        access(2'h2, ipo_pkg::IPO_OP_INDEXED, 1'b0, 8'h00, 8'h80);
        chk(1'b1, 12'h080, 2, 16'h0100);
        access(2'h2, ipo_pkg::IPO_OP_INDEXED, 1'b0, 8'h00, 8'h7F);
        chk(1'b1, 12'h17F, 2, 16'h0100);
        access(2'h2, ipo_pkg::IPO_OP_PLAIN, 1'b1, 8'hA5, 8'h00);
        `CHK(mem_we, 1'b1)
        `CHK(mem_addr, 12'h100)
        `CHK(mem_wdata, 8'hA5)
        access(2'h2, ipo_pkg::IPO_OP_PLAIN, 1'b0, 8'h00, 8'h00);
        chk(1'b1, 12'h100, 2, 16'h0100);
        @(posedge sys_clk);
        #1;
        `CHK(rdata_q, 8'hA5)
    endtask : t_index
    task automatic t_slots;
        set_ptr(0, 16'h0FE0);
        access(2'h0, ipo_pkg::IPO_OP_PLAIN, 1'b0, 8'h00, 8'h00);
        chk(1'b0, 12'h000, 0, 16'h0FE0);
        `CHK(rd_zero, 1'b1)
        // Core takes the zero at the edge that ends the pulse
        @(posedge sys_clk);
        #1;
        `CHK(rdata_q, 8'h00)
        access(2'h0, ipo_pkg::IPO_OP_PLAIN, 1'b1, 8'h33, 8'h00);
        chk(1'b0, 12'h000, 1, 16'hFFFF);
        `CHK(mem_we, 1'b0)
        `CHK(rd_zero, 1'b0)
        `CHK(ptr_pairs[0], 16'h0FE0)
    endtask : t_slots
    task automatic t_self;
        set_ptr(2, 16'h0FDD);
        access(2'h2, ipo_pkg::IPO_OP_POST_INCREMENT_OPERAND, 1'b1, 8'h5A, 8'h00);
        chk(1'b0, 12'h000, 2, 16'h0F5A);
        set_ptr(0, 16'h0FDE);
        access(2'h0, ipo_pkg::IPO_OP_POST_DECREMENT_OPERAND, 1'b1, 8'h01, 8'h00);
        chk(1'b0, 12'h000, 2, 16'h015A);
        `CHK(ptr_pairs[0], 16'h0FDD)
    endtask : t_self
    // Pairs as left by t_self: {pair2, pair1, pair0}
    task automatic t_refuse;
        access(2'h3, ipo_pkg::IPO_OP_POST_INCREMENT_OPERAND, 1'b0, 8'h00, 8'h00);
        `CHK(mem_valid, 1'b0)
        `CHK(ptr_pairs, 48'h015AFFFF0FDD)
        // Direct write lands in the same cycle as an access: access wins
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_pair <= 2'h1;
        acc_op <= ipo_pkg::IPO_OP_PLAIN;
        acc_write <= 1'b0;
        dir_we <= 1'b1;
        dir_addr <= ipo_pkg::PAIR_BASE[0] + 12'h005;
        dir_wdata <= 8'h77;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        dir_we <= 1'b0;
        #1;
        `CHK(mem_valid, 1'b1)
        `CHK(ptr_pairs, 48'h015AFFFF0FDD)
        dwrite(ipo_pkg::PAIR_BASE[0], 8'h44);
        #1;
        `CHK(ptr_pairs, 48'h015AFFFF0FDD)
    endtask : t_refuse
    initial begin
        rstn = 1'b0;
        {acc_valid, acc_write, dir_we, acc_pair, acc_wdata, work_reg} = '0;
        acc_op = ipo_pkg::IPO_OP_PLAIN;
        dir_addr = 12'h000;
        dir_wdata = 8'h00;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        t_steps();
        t_index();
        t_slots();
        t_self();
        t_refuse();
        give_verdict();
    end
endmodule : ipo_pointer_ops_tb
